// ===== sfx_slice.sv
// One nine-bit FIFO slice with registered status flags and offset registers.
`timescale 1ns/100ps
`default_nettype none
module sfx_slice #(
    parameter int SLICES = sfx_pkg::SFX_DEF_SLICES,
    parameter int SLICE = 0,
    parameter int DEPTH = sfx_pkg::SFX_DEF_DEPTH
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Pins toward the controller.
    sfx_link_if.device link,
    // Observation of the configured pin role.
    output logic load_mode
);
    import sfx_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int LO = SLICE * SFX_WORD_W;
    localparam logic [AW:0] DEPTH_COUNT = (AW + 1)'(DEPTH);

    logic [SFX_WORD_W-1:0] mem_q [DEPTH];
    logic [SFX_WORD_W-1:0] ofs_q [SFX_OFS_REGS];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic [1:0] ofs_wr_sel_q;
    logic [1:0] ofs_rd_sel_q;
    logic [SFX_WORD_W-1:0] qdata_q;
    logic load_mode_q;
    logic ff_q;
    logic ef_q;
    logic pae_q;
    logic paf_q;
    logic run;
    logic wr_req;
    logic rd_req;
    logic ofs_wr;
    logic ofs_rd;
    logic do_write;
    logic do_read;
    logic [AW:0] empty_ofs;
    logic [AW:0] full_ofs;

    // Joins an LSB/MSB offset pair into a threshold at the depth's width.
    function automatic logic [AW:0] join_ofs(input logic [SFX_WORD_W-1:0] lsb,
                                            input logic [SFX_WORD_W-1:0] msb);
        logic [2*SFX_WORD_W-1:0] whole;
        whole = {msb, lsb};
        join_ofs = {1'b0, whole[AW-1:0]};
    endfunction

    assign run = link.master_reset_n & ce;
    // Both enable styles reduce to the same write test.
    assign wr_req = ~link.write_enable_primary_n & link.write_enable_second_or_load;
    assign rd_req = ~link.read_enable_primary_n & ~link.read_enable_second_n;
    assign ofs_wr = load_mode_q & ~link.write_enable_primary_n
        & ~link.write_enable_second_or_load;
    assign ofs_rd = load_mode_q & ~link.write_enable_second_or_load & rd_req;
    assign do_write = run & wr_req & ff_q;
    assign do_read = run & rd_req & ~ofs_rd & ef_q;
    assign empty_ofs = join_ofs(ofs_q[SFX_OFS_EMPTY_LSB], ofs_q[SFX_OFS_EMPTY_MSB]);
    assign full_ofs = join_ofs(ofs_q[SFX_OFS_FULL_LSB], ofs_q[SFX_OFS_FULL_MSB]);

    // Flags follow the next count, so each one settles at the edge that moves it.
    always_comb begin
        count_d = count_q;
        if (do_write && !do_read) begin
            count_d = count_q + 1'b1;
        end else if (do_read && !do_write) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_mode_q <= 1'b1;
        end else if (ce && !link.master_reset_n) begin
            load_mode_q <= ~link.write_enable_second_or_load;
        end
    end

    // Storage has no reset, so a large depth costs no reset fan-out.
    always_ff @(posedge clk) begin
        if (do_write) begin
            mem_q[wr_ptr_q] <= link.wdata[LO +: SFX_WORD_W];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (ce && !link.master_reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_write) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_read) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (ce) begin
                count_q <= count_d;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ofs_q[SFX_OFS_EMPTY_LSB] <= SFX_OFS_LSB_RESET;
            ofs_q[SFX_OFS_EMPTY_MSB] <= SFX_OFS_MSB_RESET;
            ofs_q[SFX_OFS_FULL_LSB] <= SFX_OFS_LSB_RESET;
            ofs_q[SFX_OFS_FULL_MSB] <= SFX_OFS_MSB_RESET;
            ofs_wr_sel_q <= SFX_OFS_EMPTY_LSB;
            ofs_rd_sel_q <= SFX_OFS_EMPTY_LSB;
        end else if (ce && !link.master_reset_n) begin
            ofs_q[SFX_OFS_EMPTY_LSB] <= SFX_OFS_LSB_RESET;
            ofs_q[SFX_OFS_EMPTY_MSB] <= SFX_OFS_MSB_RESET;
            ofs_q[SFX_OFS_FULL_LSB] <= SFX_OFS_LSB_RESET;
            ofs_q[SFX_OFS_FULL_MSB] <= SFX_OFS_MSB_RESET;
            ofs_wr_sel_q <= SFX_OFS_EMPTY_LSB;
            ofs_rd_sel_q <= SFX_OFS_EMPTY_LSB;
        end else if (ce) begin
            if (ofs_wr) begin
                ofs_q[ofs_wr_sel_q] <= link.wdata[LO +: SFX_WORD_W];
                ofs_wr_sel_q <= ofs_wr_sel_q + 1'b1;
            end
            if (ofs_rd) begin
                ofs_rd_sel_q <= ofs_rd_sel_q + 1'b1;
            end
        end
    end

    // The output register keeps the last word read once the slice runs dry.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            qdata_q <= '0;
        end else if (ce && !link.master_reset_n) begin
            qdata_q <= '0;
        end else if (do_read) begin
            qdata_q <= mem_q[rd_ptr_q];
        end else if (ce && ofs_rd) begin
            qdata_q <= ofs_q[ofs_rd_sel_q];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ff_q <= 1'b1;
        end else if (ce && !link.master_reset_n) begin
            ff_q <= 1'b1;
        end else if (ce) begin
            ff_q <= (count_d != DEPTH_COUNT);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ef_q <= 1'b0;
        end else if (ce && !link.master_reset_n) begin
            ef_q <= 1'b0;
        end else if (ce) begin
            ef_q <= (count_d != '0);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pae_q <= 1'b0;
        end else if (ce && !link.master_reset_n) begin
            pae_q <= 1'b0;
        end else if (ce) begin
            pae_q <= (count_d > empty_ofs);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            paf_q <= 1'b1;
        end else if (ce && !link.master_reset_n) begin
            paf_q <= 1'b1;
        end else if (ce) begin
            paf_q <= ((DEPTH_COUNT - count_d) > full_ofs);
        end
    end

    assign link.rdata[LO +: SFX_WORD_W] = qdata_q;
    assign link.full_flag_n[SLICE] = ff_q;
    assign link.empty_flag_n[SLICE] = ef_q;
    assign link.almost_empty_flag_n[SLICE] = pae_q;
    assign link.almost_full_flag_n[SLICE] = paf_q;
    assign load_mode = load_mode_q;
endmodule
`default_nettype wire

// ===== sfx_pkg.sv
// Shared constants for the flagged FIFO slice and its controller.
package sfx_pkg;
    localparam int SFX_WORD_W = 9;
    localparam int SFX_DEF_DEPTH = 16384;
    localparam int SFX_DEF_SLICES = 2;
    localparam int SFX_BUF_DEPTH = 2;
    localparam int SFX_OFS_REGS = 4;
    localparam logic [1:0] SFX_OFS_EMPTY_LSB = 2'h0;
    localparam logic [1:0] SFX_OFS_EMPTY_MSB = 2'h1;
    localparam logic [1:0] SFX_OFS_FULL_LSB = 2'h2;
    localparam logic [1:0] SFX_OFS_FULL_MSB = 2'h3;
    localparam logic [8:0] SFX_OFS_LSB_RESET = 9'h007;
    localparam logic [8:0] SFX_OFS_MSB_RESET = 9'h000;

    typedef enum logic [0:0] {
        SFX_HOST_RESET = 1'h0,
        SFX_HOST_RUN = 1'h1
    } sfx_host_state_t;
endpackage

// ===== sfx_link_if.sv
// Pin-level link between one controller and a row of paralleled FIFO slices.
`timescale 1ns/100ps
`default_nettype none
interface sfx_link_if #(
    parameter int SLICES = 2
);
    logic master_reset_n;
    logic write_enable_primary_n;
    logic write_enable_second_or_load;
    logic read_enable_primary_n;
    logic read_enable_second_n;
    logic [SLICES*9-1:0] wdata;
    // Each slice drives its own bit and lanes of these nets.
    wire [SLICES*9-1:0] rdata;
    wire [SLICES-1:0] full_flag_n;
    wire [SLICES-1:0] empty_flag_n;
    wire [SLICES-1:0] almost_empty_flag_n;
    wire [SLICES-1:0] almost_full_flag_n;

    modport device (
        input master_reset_n,
        input write_enable_primary_n,
        input write_enable_second_or_load,
        input read_enable_primary_n,
        input read_enable_second_n,
        input wdata,
        output rdata,
        output full_flag_n,
        output empty_flag_n,
        output almost_empty_flag_n,
        output almost_full_flag_n
    );

    modport host (
        output master_reset_n,
        output write_enable_primary_n,
        output write_enable_second_or_load,
        output read_enable_primary_n,
        output read_enable_second_n,
        output wdata,
        input rdata,
        input full_flag_n,
        input empty_flag_n,
        input almost_empty_flag_n,
        input almost_full_flag_n
    );
endinterface
`default_nettype wire

// ===== sfx_skid_buf.sv
// Small valid/ready buffer held in flip-flops.
`timescale 1ns/100ps
`default_nettype none
module sfx_skid_buf #(
    parameter int W = 9,
    parameter int DEPTH = 2
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [IW-1:0] LAST_INDEX = IW'(DEPTH - 1);

    logic [W-1:0] store_q [DEPTH];
    logic [IW-1:0] wr_idx_q;
    logic [IW-1:0] rd_idx_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    function automatic logic [IW-1:0] bump(input logic [IW-1:0] idx);
        bump = (idx == LAST_INDEX) ? '0 : idx + 1'b1;
    endfunction

    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign out_data = store_q[rd_idx_q];
    assign push = in_valid & in_ready & ce;
    assign pop = out_valid & out_ready & ce;

    always_ff @(posedge clk) begin
        if (push) begin
            store_q[wr_idx_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_idx_q <= bump(wr_idx_q);
            end
            if (pop) begin
                rd_idx_q <= bump(rd_idx_q);
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sfx_ctrl.sv
// Controller that writes, reads and programs a row of paralleled slices.
`timescale 1ns/100ps
`default_nettype none
module sfx_ctrl #(
    parameter int SLICES = sfx_pkg::SFX_DEF_SLICES,
    parameter bit LOAD_MODE = 1'b1
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Pins toward the slices.
    sfx_link_if.host link,
    // Write stream.
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [SLICES*9-1:0] wr_data,
    // Read stream.
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [SLICES*9-1:0] rd_data,
    // Offset programming, one nine-bit value per beat.
    input wire logic prog_valid,
    output logic prog_ready,
    input wire logic [8:0] prog_data,
    // Status: full and empty combined over all slices, almost flags from slice 0.
    output logic all_full_n,
    output logic all_empty_n,
    output logic almost_empty_n,
    output logic almost_full_n
);
    import sfx_pkg::*;

    localparam int DW = SLICES * SFX_WORD_W;

    sfx_host_state_t state_q;
    logic out_valid;
    logic out_ready;
    logic [DW-1:0] out_data;
    logic rd_in_ready;
    logic pending_q;
    logic running;
    logic prog_go;
    logic write_go;
    logic read_go;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= SFX_HOST_RESET;
        end else if (ce) begin
            case (state_q)
                SFX_HOST_RESET: state_q <= SFX_HOST_RUN;
                SFX_HOST_RUN: state_q <= SFX_HOST_RUN;
                default: state_q <= SFX_HOST_RESET;
            endcase
        end
    end

    assign running = (state_q == SFX_HOST_RUN) & ce;
    assign all_full_n = &link.full_flag_n;
    assign all_empty_n = &link.empty_flag_n;
    assign almost_empty_n = link.almost_empty_flag_n[0];
    assign almost_full_n = link.almost_full_flag_n[0];

    assign prog_ready = running & LOAD_MODE;
    assign prog_go = prog_valid & prog_ready;
    assign out_ready = running & all_full_n & ~prog_go;
    assign write_go = out_valid & out_ready;
    // One read in flight at a time keeps the read buffer from overflowing.
    assign read_go = running & all_empty_n & rd_in_ready & ~pending_q & ~prog_go;

    assign link.master_reset_n = (state_q == SFX_HOST_RUN);
    assign link.write_enable_primary_n = ~(prog_go | write_go);
    assign link.write_enable_second_or_load = (state_q == SFX_HOST_RESET) ? ~LOAD_MODE :
        ~prog_go;
    assign link.read_enable_primary_n = ~read_go;
    assign link.read_enable_second_n = 1'b0;
    assign link.wdata = prog_go ? {SLICES{prog_data}} : out_data;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_q <= 1'b0;
        end else if (ce) begin
            pending_q <= read_go;
        end
    end

    sfx_skid_buf #(
        .W(DW),
        .DEPTH(SFX_BUF_DEPTH)
    ) u_wr_buf (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    sfx_skid_buf #(
        .W(DW),
        .DEPTH(SFX_BUF_DEPTH)
    ) u_rd_buf (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .in_valid(pending_q),
        .in_ready(rd_in_ready),
        .in_data(link.rdata),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule
`default_nettype wire

// ===== sfx_link_checker.sv
// Concurrent checks on the pins between the controller and the paralleled slices.
`timescale 1ns/100ps
`default_nettype none
module sfx_link_checker
    import sfx_pkg::*;
#(
    parameter int SLICES = 2,
    parameter int DEPTH = 16384
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Controller-driven pins.
    input wire logic master_reset_n,
    input wire logic write_enable_primary_n,
    input wire logic write_enable_second_or_load,
    input wire logic read_enable_primary_n,
    input wire logic read_enable_second_n,
    input wire logic [SLICES*9-1:0] wdata,
    // Slice-driven pins.
    input wire logic [SLICES*9-1:0] rdata,
    input wire logic [SLICES-1:0] full_flag_n,
    input wire logic [SLICES-1:0] empty_flag_n,
    input wire logic [SLICES-1:0] almost_empty_flag_n,
    input wire logic [SLICES-1:0] almost_full_flag_n
);
    logic wr_hit;
    logic rd_hit;
    logic [31:0] cnt_q;
    logic [1:0] ofs_ptr_q;
    logic [8:0] ofs_q [0:3];
    logic [31:0] n_val;
    logic [31:0] m_val;

    // The shadow level follows slice 0 only; the agreement check covers the others.
    assign wr_hit = !write_enable_primary_n && write_enable_second_or_load && full_flag_n[0];
    assign rd_hit = !read_enable_primary_n && !read_enable_second_n
        && write_enable_second_or_load && empty_flag_n[0];
    assign n_val = {14'h0, ofs_q[1], ofs_q[0]} % DEPTH;
    assign m_val = {14'h0, ofs_q[3], ofs_q[2]} % DEPTH;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 32'h0;
        end else if (!master_reset_n) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'(wr_hit) - 32'(rd_hit);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ofs_q <= '{SFX_OFS_LSB_RESET, SFX_OFS_MSB_RESET, SFX_OFS_LSB_RESET, SFX_OFS_MSB_RESET};
            ofs_ptr_q <= 2'h0;
        end else if (!master_reset_n) begin
            ofs_q <= '{SFX_OFS_LSB_RESET, SFX_OFS_MSB_RESET, SFX_OFS_LSB_RESET, SFX_OFS_MSB_RESET};
            ofs_ptr_q <= 2'h0;
        end else if (!write_enable_primary_n && !write_enable_second_or_load) begin
            ofs_q[ofs_ptr_q] <= wdata[8:0];
            ofs_ptr_q <= ofs_ptr_q + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_empty_level: assert property (empty_flag_n[0] == (cnt_q != 0))
        else $error("empty flag disagrees with fill level");
    a_full_level: assert property (full_flag_n[0] == (cnt_q != DEPTH))
        else $error("full flag disagrees with fill level");
    a_ae_level: assert property (almost_empty_flag_n[0] == (cnt_q > n_val))
        else $error("almost empty flag disagrees with offset");
    a_af_level: assert property (almost_full_flag_n[0] == ((DEPTH - cnt_q) > m_val))
        else $error("almost full flag disagrees with offset");
    a_write_shows_empty: assert property (wr_hit && master_reset_n |=> empty_flag_n[0])
        else $error("stored word did not clear empty flag");
    a_empty_holds_data: assert property (!empty_flag_n[0] && write_enable_primary_n
        && master_reset_n |=> $stable(rdata) && !empty_flag_n[0])
        else $error("read data moved while empty");
    a_full_holds: assert property (!full_flag_n[0] && read_enable_primary_n
        && master_reset_n |=> !full_flag_n[0])
        else $error("full flag left without a read");
    a_slices_agree: assert property (full_flag_n == {SLICES{full_flag_n[0]}}
        && empty_flag_n == {SLICES{empty_flag_n[0]}}
        && almost_empty_flag_n == {SLICES{almost_empty_flag_n[0]}}
        && almost_full_flag_n == {SLICES{almost_full_flag_n[0]}})
        else $error("paralleled slices disagree");
    a_load_low_reset: assert property (!master_reset_n |-> !write_enable_second_or_load)
        else $error("load pin high during slice reset");
    a_second_read_tied: assert property (!read_enable_second_n)
        else $error("second read enable not held low");
endmodule
`default_nettype wire

// ===== sync_fifo_flags_width_expansion_tb.sv
// Self-checking bench for the controller driving two paralleled slices.
`timescale 1ns/100ps
`default_nettype none
module sync_fifo_flags_width_expansion_tb;
    import sfx_pkg::*;
    localparam int DEPTH = 16384;
    logic clk, reset, wr_valid, wr_ready, rd_valid, rd_ready, prog_valid, prog_ready;
    logic [17:0] wr_data, rd_data;
    logic [8:0] prog_data;
    logic all_full_n, all_empty_n, almost_empty_n, almost_full_n;
    logic [1:0] load_mode;
    logic [17:0] exp_q [$];
    logic ce, ce_mix;
    int errors, checks_done;

    sfx_link_if #(.SLICES(2)) sfx_link_if_inst ();
    for (genvar k = 0; k < 2; k++) begin : g_slice
        sfx_slice #(.SLICES(2), .SLICE(k), .DEPTH(DEPTH)) sfx_slice_inst (.clk(clk),
            .reset(reset), .ce(ce), .link(sfx_link_if_inst), .load_mode(load_mode[k]));
    end
    sfx_ctrl sfx_ctrl_inst (.clk(clk), .reset(reset),
        .ce(ce), .link(sfx_link_if_inst), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data),
        .all_full_n(all_full_n), .all_empty_n(all_empty_n),
        .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n));
    sfx_link_checker #(.SLICES(2), .DEPTH(DEPTH)) sfx_link_checker_inst (.clk(clk),
        .reset(reset), .master_reset_n(sfx_link_if_inst.master_reset_n),
        .write_enable_primary_n(sfx_link_if_inst.write_enable_primary_n),
        .write_enable_second_or_load(sfx_link_if_inst.write_enable_second_or_load),
        .read_enable_primary_n(sfx_link_if_inst.read_enable_primary_n),
        .read_enable_second_n(sfx_link_if_inst.read_enable_second_n),
        .wdata(sfx_link_if_inst.wdata), .rdata(sfx_link_if_inst.rdata),
        .full_flag_n(sfx_link_if_inst.full_flag_n), .empty_flag_n(sfx_link_if_inst.empty_flag_n),
        .almost_empty_flag_n(sfx_link_if_inst.almost_empty_flag_n),
        .almost_full_flag_n(sfx_link_if_inst.almost_full_flag_n));

    function automatic logic above(input int cnt, input int ofs);
        return cnt > ofs;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string what);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, what);
        end_sim();
    endtask

    task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Valid stays up between calls; the caller lowers it after the last word.
    task automatic put(input logic [17:0] w, input int lim, output logic took);
        took = 1'b0;
        wr_valid <= 1'b1;
        wr_data <= w;
        for (int i = 0; i < lim && !took; i++) begin
            @(posedge clk);
            took = wr_ready && ce;
        end
        if (took) begin
            exp_q.push_back(w);
        end
    endtask

    // The reader stalls at random so the read buffer is exercised.
    task automatic get();
        logic got;
        got = 1'b0;
        for (int i = 0; i < 200 && !got; i++) begin
            rd_ready <= ($urandom % 8 != 0);
            @(posedge clk);
            got = rd_ready && rd_valid && ce;
        end
        if (!got) begin
            fail("read timeout");
        end
        check(rd_data, exp_q.pop_front(), "read word");
    endtask

    task automatic prog(input logic [8:0] v);
        logic got;
        got = 1'b0;
        prog_valid <= 1'b1;
        prog_data <= v;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge clk);
            got = prog_ready;
        end
        if (!got) begin
            fail("program timeout");
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The enable drops at random while ce_mix is set, so every stage must hold still then.
    always @(posedge clk) begin
        ce <= ce_mix ? ($urandom % 4 != 0) : 1'b1;
    end

    initial begin
        logic took;
        errors = 0;
        checks_done = 0;
        reset = 1'b1;
        ce = 1'b1;
        ce_mix = 1'b0;
        wr_valid = 1'b0;
        wr_data = 18'h0;
        rd_ready = 1'b0;
        prog_valid = 1'b0;
        prog_data = 9'h0;
        void'($urandom(32'h8470));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check({16'h0, load_mode}, 18'h3, "pin role");
        check({14'h0, all_empty_n, all_full_n, almost_empty_n, almost_full_n}, 18'h5,
            "idle");
        ce_mix <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            put(18'($urandom), 50, took);
            if (!took) fail("write timeout");
        end
        wr_valid <= 1'b0;
        ce_mix <= 1'b0;
        repeat (8) @(posedge clk);
        check({17'h0, almost_empty_n}, {17'h0, above(10, 7)}, "default empty offset");
        check({17'h0, all_empty_n}, 18'h1, "composite empty");
        ce_mix <= 1'b1;
        while (exp_q.size() > 0) get();
        rd_ready <= 1'b0;
        ce_mix <= 1'b0;
        repeat (6) @(posedge clk);
        prog(9'h003);
        prog(9'h000);
        prog(9'h005);
        prog(9'h000);
        prog_valid <= 1'b0;
        // Two words sit in the read buffer while the reader stalls.
        for (int i = 0; i < 6; i++) begin
            put(18'($urandom), 50, took);
        end
        wr_valid <= 1'b0;
        repeat (8) @(posedge clk);
        check({17'h0, almost_empty_n}, {17'h0, above(4, 3)}, "programmed offset");
        took = 1'b1;
        for (int i = 0; i < DEPTH + 20 && took; i++) begin
            put(18'($urandom), 30, took);
        end
        wr_valid <= 1'b0;
        repeat (4) @(posedge clk);
        check(18'(exp_q.size() >= DEPTH), 18'h1, "depth held");
        check({15'h0, all_full_n, almost_full_n, wr_ready}, {15'h0, 1'b0, above(0, 5), 1'b0},
            "full");
        while (exp_q.size() > 0) get();
        rd_ready <= 1'b0;
        repeat (6) @(posedge clk);
        check({14'h0, all_empty_n, all_full_n, almost_empty_n, almost_full_n}, 18'h5,
            "drained");
        end_sim();
    end
endmodule
`default_nettype wire
